// [rtl/tpr_defines.svh]
`ifndef TPR_DEFINES_SVH
`define TPR_DEFINES_SVH

// Sleep request field inside the processor control/status word
`define TPR_SLEEP_LSB       10
`define TPR_SLEEP_MSB       15
`define TPR_SLEEP_W         6
`define TPR_SLEEP_NONE      6'h00
`define TPR_CLOCK_HALT      6'h1A
`define TPR_PLL_INPUT_STOP  6'h1C

// Emulation select pair value that selects emulation mode
`define TPR_SEL_EMULATION   2'h3

// Variant field value, arbitrary
`define TPR_VARIANT         4'h5
`define TPR_VARIANT_W       4

`define TPR_PC_W            32

// Timing
`define TPR_CLK_NS          5
`define TPR_TCK_PERIOD_NS   80
`define TPR_TCK_HALF        ((`TPR_TCK_PERIOD_NS / `TPR_CLK_NS) / 2)
`define TPR_INIT_TCKS       8
`define TPR_WAIT_TCKS       16
`define TPR_CNT_W           8

`endif

// [rtl/tpr_pkg.sv]
`include "tpr_defines.svh"

package tpr_pkg;

    typedef enum logic [1:0] {TPR_CMD_NONE, TPR_CMD_STEP, TPR_CMD_RUN, TPR_CMD_PC_WRITE} tpr_cmd_t;
    typedef enum logic [1:0] {TPR_RSP_OK, TPR_RSP_FAIL, TPR_RSP_SPIN} tpr_resp_t;
    typedef enum logic [2:0] {C_INIT, C_RELEASE, C_IDLE, C_SEND, C_WAIT} tpr_ctl_st_t;

    typedef struct packed {
        logic                     tck_s1;
        logic                     tck_s2;
        logic                     tck_d;
        logic                     trst_s1;
        logic                     trst_s2;
        logic                     srst_s1;
        logic                     srst_s2;
        logic                     att_s1;
        logic                     att_s2;
        logic [1:0]               sel_s1;
        logic [1:0]               sel_s2;
        logic                     cv_s1;
        logic                     cv_s2;
        tpr_cmd_t                 cc_s1;
        tpr_cmd_t                 cc_s2;
        logic [`TPR_PC_W-1:0]     cd_s1;
        logic [`TPR_PC_W-1:0]     cd_s2;
        logic                     trst_smp;
        logic                     emu_rst;
        logic                     core_rst;
        logic                     deep;
        logic                     emu_idle;
        logic                     mode_emul;
        logic                     mode_valid;
        logic                     variant_valid;
        logic [`TPR_VARIANT_W-1:0] variant;
        logic [`TPR_SLEEP_W-1:0]  sleep_field;
        logic                     exec_step;
        logic                     exec_run;
        logic                     pc_wr;
        logic [`TPR_PC_W-1:0]     pc_data;
        logic                     pend;
        tpr_resp_t                pend_code;
        logic                     resp_valid;
        tpr_resp_t                resp_code;
    } tpr_dev_state_t;

    typedef struct packed {
        logic [`TPR_CNT_W-1:0]    div;
        logic                     tck;
        logic                     trst_o;
        logic                     trst_oe;
        logic                     srst_n;
        logic [`TPR_CNT_W-1:0]    cnt;
        tpr_ctl_st_t              st;
        logic                     cv;
        tpr_cmd_t                 cc;
        logic [`TPR_PC_W-1:0]     cd;
        logic                     rv_s1;
        logic                     rv_s2;
        tpr_resp_t                rc_s1;
        tpr_resp_t                rc_s2;
        logic                     busy;
        logic                     done;
        tpr_resp_t                result;
    } tpr_ctl_state_t;

endpackage

// [rtl/tpr_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpr_defines.svh"

interface tpr_link_if;
    import tpr_pkg::*;

    logic                  test_clock;
    logic                  test_rst_n_out;
    logic                  test_rst_n_oe;
    logic                  test_rst_n;
    logic                  sys_rst_n;
    logic [1:0]            emulation_select_pair;
    logic                  emu_attached;
    logic                  cmd_valid;
    tpr_cmd_t              cmd_code;
    logic [`TPR_PC_W-1:0]  cmd_data;
    logic                  resp_valid;
    tpr_resp_t             resp_code;

    // Undriven test reset reads low through the internal pulldown
    assign test_rst_n = test_rst_n_oe ? test_rst_n_out : 1'b0;

    modport dev (
        input  test_clock,
        input  test_rst_n,
        input  sys_rst_n,
        input  emulation_select_pair,
        input  emu_attached,
        input  cmd_valid,
        input  cmd_code,
        input  cmd_data,
        output resp_valid,
        output resp_code
    );

    modport ctl (
        output test_clock,
        output test_rst_n_out,
        output test_rst_n_oe,
        output sys_rst_n,
        output emulation_select_pair,
        output emu_attached,
        output cmd_valid,
        output cmd_code,
        output cmd_data,
        input  resp_valid,
        input  resp_code
    );

endinterface

`default_nettype wire

// [rtl/tpr_dev.sv]
// Behaviour
// - Attached emulator masks programmed sleep modes
// - Masking holds until emulator detach
// - Deep sleep: step/run commands spin idle
// - Deep sleep: PC writes ignored, reported failed
// - Only system reset leaves deep sleep
// - Both resets asserted at power-up
// - Test reset sampled on test clock
// - Core boots on system reset release alone
// - Held test reset keeps emulation logic reset
// - Variant field valid only after system reset
// - Test reset pin pulled down internally
// - Controller drives test reset high before use
// - Latch select pair on test reset rise, only if core is out of reset
// - Latched pair picks scan or emulation mode
// - Sleep request is control word bits 15-10
`timescale 1ns/1ps
`default_nettype none
`include "tpr_defines.svh"

module tpr_dev
    import tpr_pkg::*;
(
    input  wire logic                      clk_sys_i,
    input  wire logic                      sys_rst_i,
    tpr_link_if.dev                        link,
    input  wire logic [31:0]               processor_control_status_i,
    output logic                           core_rst_o,
    output logic                           emu_rst_o,
    output logic [`TPR_SLEEP_W-1:0]        sleep_mode_field_o,
    output logic                           deep_sleep_o,
    output logic                           emu_idle_o,
    output logic                           mode_emulation_o,
    output logic                           mode_valid_o,
    output logic [`TPR_VARIANT_W-1:0]      variant_o,
    output logic                           variant_valid_o,
    output logic                           exec_step_o,
    output logic                           exec_run_o,
    output logic                           pc_wr_o,
    output logic [`TPR_PC_W-1:0]           pc_wr_data_o
);

    tpr_dev_state_t r;
    tpr_dev_state_t n;

    logic                    tck_rise;
    logic                    tck_fall;
    logic [`TPR_SLEEP_W-1:0] req_field;
    logic                    mask_sleep;
    logic                    deep_code;

    // Test clock edges, seen two system clocks after the pin moves
    assign tck_rise  = r.tck_s2 & ~r.tck_d;
    assign tck_fall  = ~r.tck_s2 & r.tck_d;
    assign req_field = processor_control_status_i[`TPR_SLEEP_MSB:`TPR_SLEEP_LSB];

    // Sleep requests are void while an emulator is attached or the core is in reset
    assign mask_sleep = r.core_rst | r.att_s2;
    assign deep_code  = (r.sleep_field == `TPR_CLOCK_HALT) ||
                        (r.sleep_field == `TPR_PLL_INPUT_STOP);

    always_comb begin
        n = r;
        // Pin synchronisers
        // Command code and data are steady well before cmd_valid passes its stages
        n.tck_s1  = link.test_clock;
        n.tck_s2  = r.tck_s1;
        n.tck_d   = r.tck_s2;
        n.trst_s1 = link.test_rst_n;
        n.trst_s2 = r.trst_s1;
        n.srst_s1 = link.sys_rst_n;
        n.srst_s2 = r.srst_s1;
        n.att_s1  = link.emu_attached;
        n.att_s2  = r.att_s1;
        n.sel_s1  = link.emulation_select_pair;
        n.sel_s2  = r.sel_s1;
        n.cv_s1   = link.cmd_valid;
        n.cv_s2   = r.cv_s1;
        n.cc_s1   = link.cmd_code;
        n.cc_s2   = r.cc_s1;
        n.cd_s1   = link.cmd_data;
        n.cd_s2   = r.cd_s1;

        // Strobes last one system clock
        n.exec_step = 1'b0;
        n.exec_run  = 1'b0;
        n.pc_wr     = 1'b0;

        // Core reset follows system reset only, test reset plays no part
        n.core_rst      = ~r.srst_s2;
        n.variant_valid = r.srst_s2 & ~r.core_rst;
        if (r.srst_s2 && !r.core_rst) begin
            n.variant = `TPR_VARIANT;
        end else begin
            n.variant = '0;
        end

        // Sleep request passes only while no emulator is attached
        if (mask_sleep) begin
            n.sleep_field = `TPR_SLEEP_NONE;
        end else begin
            n.sleep_field = req_field;
        end

        // Deep sleep is sticky; nothing but system reset clears it
        if (r.core_rst) begin
            n.deep     = 1'b0;
            n.emu_idle = 1'b0;
        end else if (deep_code) begin
            n.deep = 1'b1;
        end

        // Emulation logic works on test clock rising edges
        if (tck_rise) begin
            n.trst_smp = r.trst_s2;
            n.emu_rst  = ~r.trst_s2;
            if (!r.trst_s2) begin
                n.mode_valid = 1'b0;
                n.pend       = 1'b0;
            end else if (!r.trst_smp) begin
                // First rise with test reset high latches the pair unless the core is in reset, takes no command
                if (!r.core_rst) begin
                    n.mode_emul  = (r.sel_s2 == `TPR_SEL_EMULATION);
                    n.mode_valid = 1'b1;
                end
            end else if (r.cv_s2) begin
                // One command per rise once the port is out of reset
                n.pend = 1'b1;
                case (r.cc_s2)
                    TPR_CMD_STEP, TPR_CMD_RUN: begin
                        // A stopped core cannot step or run; answer with spin
                        if (r.deep) begin
                            n.emu_idle  = 1'b1;
                            n.pend_code = TPR_RSP_SPIN;
                        end else begin
                            n.exec_step = (r.cc_s2 == TPR_CMD_STEP);
                            n.exec_run  = (r.cc_s2 == TPR_CMD_RUN);
                            n.pend_code = TPR_RSP_OK;
                        end
                    end
                    TPR_CMD_PC_WRITE: begin
                        // Core clocks are stopped, so the write cannot land
                        if (r.deep) begin
                            n.pend_code = TPR_RSP_FAIL;
                        end else begin
                            n.pc_wr     = 1'b1;
                            n.pc_data   = r.cd_s2;
                            n.pend_code = TPR_RSP_OK;
                        end
                    end
                    default: begin
                        n.pend_code = TPR_RSP_OK;
                    end
                endcase
            end
        end

        // Answer changes on falling edges so it is stable at the next rise
        if (tck_fall) begin
            n.pend = 1'b0;
            if (r.pend && !r.emu_rst) begin
                n.resp_valid = 1'b1;
                n.resp_code  = r.pend_code;
            end else begin
                n.resp_valid = 1'b0;
            end
        end
    end

    // Emulation side and core both start held in reset
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            r               <= '0;
            r.trst_smp      <= 1'b0;
            r.emu_rst       <= 1'b1;
            r.core_rst      <= 1'b1;
            r.pend_code     <= TPR_RSP_OK;
            r.resp_code     <= TPR_RSP_OK;
            r.cc_s1         <= TPR_CMD_NONE;
            r.cc_s2         <= TPR_CMD_NONE;
        end else begin
            r <= n;
        end
    end

    // Answer to the controller
    assign link.resp_valid = r.resp_valid;
    assign link.resp_code  = r.resp_code;

    // Every output is a state register bit
    assign core_rst_o         = r.core_rst;
    assign emu_rst_o          = r.emu_rst;
    assign sleep_mode_field_o = r.sleep_field;
    assign deep_sleep_o       = r.deep;
    assign emu_idle_o         = r.emu_idle;
    assign mode_emulation_o   = r.mode_emul;
    assign mode_valid_o       = r.mode_valid;
    assign variant_o          = r.variant;
    assign variant_valid_o    = r.variant_valid;
    assign exec_step_o        = r.exec_step;
    assign exec_run_o         = r.exec_run;
    assign pc_wr_o            = r.pc_wr;
    assign pc_wr_data_o       = r.pc_data;

endmodule

`default_nettype wire

// [rtl/tpr_ctl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpr_defines.svh"

module tpr_ctl
    import tpr_pkg::*;
#(
    parameter logic [`TPR_CNT_W-1:0] TCK_HALF   = `TPR_CNT_W'(`TPR_TCK_HALF),
    parameter logic [`TPR_CNT_W-1:0] INIT_TCKS  = `TPR_CNT_W'(`TPR_INIT_TCKS),
    parameter logic [`TPR_CNT_W-1:0] WAIT_TCKS  = `TPR_CNT_W'(`TPR_WAIT_TCKS)
)
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  sys_rst_i,
    tpr_link_if.ctl                    link,
    input  wire logic                  attach_i,
    input  wire logic [1:0]            emulation_select_pair_i,
    input  wire logic                  test_rst_req_i,
    input  wire logic                  sys_rst_req_i,
    input  wire logic                  start_i,
    input  wire tpr_cmd_t              cmd_i,
    input  wire logic [`TPR_PC_W-1:0]  data_i,
    output logic                       busy_o,
    output logic                       done_o,
    output tpr_resp_t                  result_o,
    output logic                       ready_o
);

    tpr_ctl_state_t r;
    tpr_ctl_state_t n;
    logic           rise;
    logic           fall;

    always_comb begin
        n    = r;
        rise = 1'b0;
        fall = 1'b0;
        // Free-running test clock, kept running through test reset
        if (r.div == TCK_HALF - 1'b1) begin
            n.div = '0;
            n.tck = ~r.tck;
            rise  = ~r.tck;
            fall  = r.tck;
        end else begin
            n.div = r.div + 1'b1;
        end
        n.rv_s1 = link.resp_valid;
        n.rv_s2 = r.rv_s1;
        n.rc_s1 = link.resp_code;
        n.rc_s2 = r.rc_s1;
        n.done  = 1'b0;
        n.trst_oe = 1'b1;

        if (start_i && !r.busy && r.st != C_INIT) begin
            n.busy = 1'b1;
            n.cc   = cmd_i;
            n.cd   = data_i;
        end

        case (r.st)
            C_INIT: begin
                // Pin released: the pulldown holds test reset asserted
                n.trst_oe = 1'b0;
                n.srst_n = 1'b0;
                n.trst_o = 1'b0;
                if (rise) begin
                    n.cnt = r.cnt + 1'b1;
                    if (r.cnt == INIT_TCKS - 1'b1) begin
                        n.cnt    = '0;
                        n.srst_n = 1'b1;
                        n.st     = C_RELEASE;
                    end
                end
            end
            C_RELEASE: begin
                // Test reset rises after system reset so the select pair latches
                if (fall) begin
                    n.trst_o = 1'b1;
                    n.st     = C_IDLE;
                end
            end
            C_IDLE: begin
                if (fall) begin
                    n.trst_o = ~test_rst_req_i;
                    n.srst_n = ~sys_rst_req_i;
                    if (r.busy && r.trst_o && !test_rst_req_i && !sys_rst_req_i) begin
                        n.cv = 1'b1;
                        n.st = C_SEND;
                    end
                end
            end
            C_SEND: begin
                if (fall) begin
                    n.cv  = 1'b0;
                    n.cnt = '0;
                    n.st  = C_WAIT;
                end
            end
            C_WAIT: begin
                if (rise) begin
                    n.cnt = r.cnt + 1'b1;
                    if (r.rv_s2) begin
                        n.done   = 1'b1;
                        n.result = r.rc_s2;
                        n.busy   = 1'b0;
                        n.st     = C_IDLE;
                    end else if (r.cnt == WAIT_TCKS - 1'b1) begin
                        n.done   = 1'b1;
                        n.result = TPR_RSP_FAIL;
                        n.busy   = 1'b0;
                        n.st     = C_IDLE;
                    end
                end
            end
            default: begin
                n.st = C_INIT;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            r         <= '0;
            r.trst_oe <= 1'b1;
            r.st      <= C_INIT;
            r.cc      <= TPR_CMD_NONE;
            r.rc_s1   <= TPR_RSP_OK;
            r.rc_s2   <= TPR_RSP_OK;
            r.result  <= TPR_RSP_OK;
        end else begin
            r <= n;
        end
    end

    assign link.test_clock            = r.tck;
    assign link.test_rst_n_out        = r.trst_o;
    assign link.test_rst_n_oe         = r.trst_oe;
    assign link.sys_rst_n             = r.srst_n;
    assign link.emulation_select_pair = emulation_select_pair_i;
    assign link.emu_attached          = attach_i;
    assign link.cmd_valid             = r.cv;
    assign link.cmd_code              = r.cc;
    assign link.cmd_data              = r.cd;

    assign busy_o   = r.busy;
    assign done_o   = r.done;
    assign result_o = r.result;
    assign ready_o  = ~r.busy & (r.st == C_IDLE);

endmodule

`default_nettype wire

// [sim/tpr_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpr_defines.svh"

// Half test clock period fixed at the default of 8 system clocks
module tpr_asserts
    import tpr_pkg::*;
(
    input  wire logic                     clk_sys_i,
    input  wire logic                     sys_rst_i,
    input  wire logic                     test_clock,
    input  wire logic                     test_rst_n_out,
    input  wire logic                     test_rst_n_oe,
    input  wire logic                     test_rst_n,
    input  wire logic                     sys_rst_n,
    input  wire logic                     cmd_valid,
    input  wire tpr_cmd_t                 cmd_code,
    input  wire logic [`TPR_PC_W-1:0]     cmd_data,
    input  wire logic                     resp_valid,
    input  wire tpr_resp_t                resp_code
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    a_both_resets_low: assert property (
        $fell(sys_rst_i) |-> !sys_rst_n && !test_rst_n)
        else $error("link resets not both low after power-up");
    a_srst_before_trst: assert property (
        $rose(test_rst_n) |-> sys_rst_n)
        else $error("test reset released before system reset");
    a_trst_tck_low: assert property (
        $rose(test_rst_n) |-> !test_clock)
        else $error("test reset released while test clock high");
    a_tck_high_half: assert property (
        $rose(test_clock) |-> test_clock [*8] ##1 !test_clock)
        else $error("test clock high phase wrong");
    a_tck_low_half: assert property (
        $fell(test_clock) |-> !test_clock [*8] ##1 test_clock)
        else $error("test clock low phase wrong");
    a_trst_pulldown: assert property (
        test_rst_n == (test_rst_n_oe & test_rst_n_out))
        else $error("resolved test reset wrong");
    a_resp_after_cmd: assert property (
        $rose(resp_valid) |-> $past(cmd_valid, 8) && test_rst_n)
        else $error("response without command or in test reset");
    a_resp_stands: assert property (
        $rose(resp_valid) |=> (resp_valid && $stable(resp_code)) [*7])
        else $error("response not held");
    a_resp_gap: assert property (
        $fell(resp_valid) |=> !resp_valid [*8])
        else $error("responses too close");
    a_cmd_stable: assert property (
        cmd_valid && $past(cmd_valid) |-> $stable(cmd_code) && $stable(cmd_data))
        else $error("command changed while valid");
    a_cmd_when_live: assert property (
        $rose(cmd_valid) |-> test_rst_n && sys_rst_n)
        else $error("command sent during a reset");
endmodule

`default_nettype wire

// [sim/test_tpr.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpr_defines.svh"

module test_tpr
    import tpr_pkg::*;
;
    logic        clk_sys_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        attach_i;
    logic        test_rst_req_i;
    logic        sys_rst_req_i;
    logic        start_i;
    logic [1:0]  sel_i;
    tpr_cmd_t    cmd_i;
    logic [31:0] data_i;
    logic [31:0] pcs_i;
    logic        busy_o, done_o, ready_o;
    tpr_resp_t   result_o;
    logic        core_rst_o, emu_rst_o, deep_sleep_o, emu_idle_o;
    logic        mode_emulation_o, mode_valid_o, variant_valid_o;
    logic        exec_step_o, exec_run_o, pc_wr_o;
    logic [5:0]  sleep_mode_field_o;
    logic [3:0]  variant_o;
    logic [31:0] pc_wr_data_o;
    int          miscompares = 0;
    int          tests_run = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;

    tpr_link_if u_tpr_link_if ();

    tpr_dev u_tpr_dev (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(u_tpr_link_if),
        .processor_control_status_i(pcs_i), .core_rst_o(core_rst_o),
        .emu_rst_o(emu_rst_o), .sleep_mode_field_o(sleep_mode_field_o),
        .deep_sleep_o(deep_sleep_o), .emu_idle_o(emu_idle_o),
        .mode_emulation_o(mode_emulation_o), .mode_valid_o(mode_valid_o),
        .variant_o(variant_o), .variant_valid_o(variant_valid_o),
        .exec_step_o(exec_step_o), .exec_run_o(exec_run_o), .pc_wr_o(pc_wr_o),
        .pc_wr_data_o(pc_wr_data_o));

    tpr_ctl u_tpr_ctl (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(u_tpr_link_if),
        .attach_i(attach_i), .emulation_select_pair_i(sel_i),
        .test_rst_req_i(test_rst_req_i), .sys_rst_req_i(sys_rst_req_i),
        .start_i(start_i), .cmd_i(cmd_i), .data_i(data_i), .busy_o(busy_o),
        .done_o(done_o), .result_o(result_o), .ready_o(ready_o));

    tpr_asserts u_tpr_asserts (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .test_clock(u_tpr_link_if.test_clock),
        .test_rst_n_out(u_tpr_link_if.test_rst_n_out),
        .test_rst_n_oe(u_tpr_link_if.test_rst_n_oe),
        .test_rst_n(u_tpr_link_if.test_rst_n), .sys_rst_n(u_tpr_link_if.sys_rst_n),
        .cmd_valid(u_tpr_link_if.cmd_valid), .cmd_code(u_tpr_link_if.cmd_code),
        .cmd_data(u_tpr_link_if.cmd_data), .resp_valid(u_tpr_link_if.resp_valid),
        .resp_code(u_tpr_link_if.resp_code));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One command through the controller; seen collects {step, run, pc write} pulses, checked against ep
    task automatic run_cmd(input tpr_cmd_t c, input logic [31:0] d, input tpr_resp_t er,
                           input logic [2:0] ep);
        logic [2:0] seen;
        int         n;
        seen = 3'h0;
        n = 0;
        start_i <= 1'b1;
        cmd_i <= c;
        data_i <= d;
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        while (done_o !== 1'b1 && n < 400) begin
            @(posedge clk_sys_i);
            seen = seen | {exec_step_o, exec_run_o, pc_wr_o};
            n++;
        end
        check("done", {31'h0, done_o}, 32'h1);
        check("busy", {31'h0, busy_o}, 32'h0);
        check("result", {30'h0, result_o}, {30'h0, er});
        check("pulses", {29'h0, seen}, {29'h0, ep});
    endtask

    function automatic logic [31:0] sleep_req(input logic [5:0] f);
        return {16'h0, f, 10'h0};
    endfunction

    initial begin
        int n;
        attach_i = 1'b0;
        test_rst_req_i = 1'b0;
        sys_rst_req_i = 1'b0;
        start_i = 1'b0;
        sel_i = `TPR_SEL_EMULATION;
        cmd_i = TPR_CMD_NONE;
        data_i = 32'h0;
        pcs_i = 32'h0;
        tick(18);
        check("core_rst", {31'h0, core_rst_o}, 32'h1);
        check("emu_rst", {31'h0, emu_rst_o}, 32'h1);
        check("variant", {28'h0, variant_o}, 32'h0);
        tick(2);
        sys_rst_i <= 1'b0;
        tick(4);
        check("trst_oe", {31'h0, u_tpr_link_if.test_rst_n_oe}, 32'h0);
        check("trst", {31'h0, u_tpr_link_if.test_rst_n}, 32'h0);
        n = 0;
        while (ready_o !== 1'b1 && n < 1000) begin
            tick(1);
            n++;
        end
        tick(64);
        check("core_rst", {31'h0, core_rst_o}, 32'h0);
        check("emu_rst", {31'h0, emu_rst_o}, 32'h0);
        check("ready", {31'h0, ready_o}, 32'h1);
        check("variant_valid", {31'h0, variant_valid_o}, 32'h1);
        check("variant", {28'h0, variant_o}, {28'h0, `TPR_VARIANT});
        check("mode_valid", {31'h0, mode_valid_o}, 32'h1);
        check("mode_emulation", {31'h0, mode_emulation_o}, 32'h1);
        run_cmd(TPR_CMD_STEP, 32'h0, TPR_RSP_OK, 3'h4);
        run_cmd(TPR_CMD_RUN, 32'h0, TPR_RSP_OK, 3'h2);
        run_cmd(TPR_CMD_PC_WRITE, 32'hA5C3_0F1E, TPR_RSP_OK, 3'h1);
        check("pc_data", pc_wr_data_o, 32'hA5C3_0F1E);
        run_cmd(TPR_CMD_NONE, 32'h0, TPR_RSP_OK, 3'h0);
        attach_i <= 1'b1;
        // Attach passes two stages, the request none: attach first
        tick(8);
        pcs_i <= sleep_req(`TPR_CLOCK_HALT);
        tick(8);
        check("sleep_field", {26'h0, sleep_mode_field_o}, 32'h0);
        check("deep", {31'h0, deep_sleep_o}, 32'h0);
        pcs_i <= sleep_req(`TPR_PLL_INPUT_STOP);
        tick(8);
        check("sleep_field", {26'h0, sleep_mode_field_o}, 32'h0);
        run_cmd(TPR_CMD_STEP, 32'h0, TPR_RSP_OK, 3'h4);
        attach_i <= 1'b0;
        pcs_i <= sleep_req(6'h09);
        tick(8);
        check("sleep_field", {26'h0, sleep_mode_field_o}, 32'h0000_0009);
        check("deep", {31'h0, deep_sleep_o}, 32'h0);
        pcs_i <= sleep_req(`TPR_PLL_INPUT_STOP);
        tick(8);
        check("sleep_field", {26'h0, sleep_mode_field_o}, {26'h0, `TPR_PLL_INPUT_STOP});
        check("deep", {31'h0, deep_sleep_o}, 32'h1);
        run_cmd(TPR_CMD_STEP, 32'h0, TPR_RSP_SPIN, 3'h0);
        check("emu_idle", {31'h0, emu_idle_o}, 32'h1);
        run_cmd(TPR_CMD_RUN, 32'h0, TPR_RSP_SPIN, 3'h0);
        run_cmd(TPR_CMD_PC_WRITE, 32'h1234_5678, TPR_RSP_FAIL, 3'h0);
        pcs_i <= 32'h0;
        tick(64);
        check("deep", {31'h0, deep_sleep_o}, 32'h1);
        sys_rst_req_i <= 1'b1;
        tick(64);
        check("core_rst", {31'h0, core_rst_o}, 32'h1);
        check("deep", {31'h0, deep_sleep_o}, 32'h0);
        check("emu_idle", {31'h0, emu_idle_o}, 32'h0);
        check("variant_valid", {31'h0, variant_valid_o}, 32'h0);
        test_rst_req_i <= 1'b1;
        sel_i <= 2'h1;
        tick(64);
        check("emu_rst", {31'h0, emu_rst_o}, 32'h1);
        check("mode_valid", {31'h0, mode_valid_o}, 32'h0);
        sys_rst_req_i <= 1'b0;
        tick(64);
        check("core_rst", {31'h0, core_rst_o}, 32'h0);
        check("emu_rst", {31'h0, emu_rst_o}, 32'h1);
        check("variant_valid", {31'h0, variant_valid_o}, 32'h1);
        test_rst_req_i <= 1'b0;
        tick(64);
        check("emu_rst", {31'h0, emu_rst_o}, 32'h0);
        check("mode_valid", {31'h0, mode_valid_o}, 32'h1);
        check("mode_emulation", {31'h0, mode_emulation_o}, 32'h0);
        run_cmd(TPR_CMD_STEP, 32'h0, TPR_RSP_OK, 3'h4);
        test_done();
    end

    // Whole run needs about a thousand cycles
    initial begin
        tick(30000);
        miscompares++;
        test_done();
    end
endmodule

`default_nettype wire
